// ===== rtl/voice_dac_pkg.sv
// Register map, field layout and timing constants for the voice ROM and DAC block
package voice_dac_pkg;

  // ----------------------------------------
  // Register offsets in CPU data memory
  // ----------------------------------------
  localparam logic [7:0] OFF_ROM_ADDR0_HIGH = 8'h18;
  localparam logic [7:0] OFF_ROM_ADDR0_MID = 8'h19;
  localparam logic [7:0] OFF_ROM_ADDR0_LOW = 8'h1A;
  localparam logic [7:0] OFF_ROM_ADDR1_HIGH = 8'h1B;
  localparam logic [7:0] OFF_ROM_ADDR1_MID = 8'h1C;
  localparam logic [7:0] OFF_ROM_ADDR1_LOW = 8'h1D;
  localparam logic [7:0] OFF_VOICE_CONTROL = 8'h26;
  localparam logic [7:0] OFF_AUDIO_SAMPLE_LOW = 8'h27;
  localparam logic [7:0] OFF_AUDIO_SAMPLE_HIGH = 8'h28;
  localparam logic [7:0] OFF_OUTPUT_VOLUME = 8'h29;
  localparam logic [7:0] OFF_ROM_READ_DATA = 8'h2A;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int CTRL_DAC_EN_BIT = 1;
  localparam int CTRL_ROM_EN_BIT = 2;
  localparam int CTRL_SEL_BIT = 4;
  localparam int CTRL_NORMAL_START_BIT = 7;
  localparam logic [7:0] VOICE_CONTROL_RESET = 8'h00;
  localparam int ROM_ADDR_W = 21;
  localparam int ROM_HIGH_W = 5;
  localparam int SAMPLE_W = 12;
  localparam int VOL_LEVEL_W = 3;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 25000;
  localparam int ROM_LATENCY_NS = 4;
  localparam int ROM_LAT_CYCLES = (ROM_LATENCY_NS * 1000 * 1000 + CLK_PERIOD_PS - 1)
                                  / CLK_PERIOD_PS;
  localparam int LAT_W = $clog2(ROM_LAT_CYCLES + 1);
  localparam logic [LAT_W-1:0] LAT_LOAD = LAT_W'(ROM_LAT_CYCLES);

endpackage : voice_dac_pkg

// ===== rtl/voice_dac_ctrl.sv
// Voice ROM address latch counters, ROM data latch and 12-bit DAC register block
//
// Summary of operation
// [R01] - The 12-bit sample is the high sample byte followed by the upper nibble of the low byte.
// [R02] - The lower nibble of the low sample register always reads as zero.
// [R03] - The upper nibble of the volume register picks one of eight output volume levels.
// [R04] - The lower nibble of the volume register always reads as zero.
// [R05] - Control bit 1 enables the DAC; while it is clear the DAC output is not valid.
// [R06] - Halt leaves the DAC enable alone; only a software write changes it.
// [R07] - Control bit 2 enables the voice ROM; while it is clear no ROM data is reachable.
// [R08] - Control bit 4 picks address counter zero or counter one to address the ROM.
// [R09] - Control bit 7 picks speed-up start (0, the default) or normal start of the crystal.
// [R10] - The ROM byte address is the 21 bits of high, middle and low bytes of the counter.
// [R11] - The addressed byte needs at least 4 us to be latched before software reads it.
// [R12] - The ROM data register returns the byte latched from the selected counter's address.
// [R13] - A write to any byte of the selected counter restarts the fetch and its latency.
// [R14] - Control bits 0, 3, 5 and 6 ignore writes and read as zero.
`timescale 1ns/1ps
`default_nettype none

module voice_dac_ctrl
  import voice_dac_pkg::*;
(
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RESETN,
  // CPU data memory access
  input wire logic [7:0] I_ADDR,
  input wire logic I_WR_EN,
  input wire logic [7:0] I_WDATA,
  input wire logic I_RD_EN,
  output logic [7:0] O_RDATA,
  output logic O_RDATA_VALID,
  // Core power state
  input wire logic I_HALT,
  // Voice ROM
  output logic O_ROM_EN,
  output logic [ROM_ADDR_W-1:0] O_ROM_ADDR,
  input wire logic [7:0] I_ROM_DATA,
  output logic O_ROM_READY,
  // DAC and crystal
  output logic O_DAC_EN,
  output logic [SAMPLE_W-1:0] O_DAC_SAMPLE,
  output logic [VOL_LEVEL_W-1:0] O_VOLUME,
  output logic O_XTAL_NORMAL_START
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic dac_en;
    logic rom_en;
    logic sel;
    logic normal_start;
    logic [3:0] sample_lo;
    logic [7:0] sample_hi;
    logic [3:0] output_volume;
    logic [ROM_ADDR_W-1:0] addr0;
    logic [ROM_ADDR_W-1:0] addr1;
    logic [ROM_ADDR_W-1:0] rom_addr;
    logic [7:0] rom_data;
    logic [LAT_W-1:0] lat_cnt;
    logic rom_ready;
    logic [7:0] rdata;
    logic rdata_valid;
    logic [SAMPLE_W-1:0] dac_out;
  } state_t;

  state_t st_reg;
  state_t st_next;
  logic restart;

  // ----------------------------------------
  // Decoding
  // ----------------------------------------
  function automatic logic is_sel_addr(input logic [7:0] addr, input logic sel);
    logic hit0;
    logic hit1;
    hit0 = (addr == OFF_ROM_ADDR0_HIGH) || (addr == OFF_ROM_ADDR0_MID) ||
           (addr == OFF_ROM_ADDR0_LOW);
    hit1 = (addr == OFF_ROM_ADDR1_HIGH) || (addr == OFF_ROM_ADDR1_MID) ||
           (addr == OFF_ROM_ADDR1_LOW);
    return sel ? hit1 : hit0;
  endfunction : is_sel_addr

  function automatic logic [ROM_ADDR_W-1:0] addr_write(
    input logic [ROM_ADDR_W-1:0] cur,
    input logic [1:0] which,
    input logic [7:0] data
  );
    logic [ROM_ADDR_W-1:0] res;
    res = cur;
    unique case (which)
      2'h0: res[ROM_ADDR_W-1:16] = data[ROM_HIGH_W-1:0];
      2'h1: res[15:8] = data;
      2'h2: res[7:0] = data;
      default: res = cur;
    endcase
    return res;
  endfunction : addr_write

  function automatic logic [7:0] reg_read(input state_t s, input logic [7:0] addr);
    logic [7:0] v;
    v = 8'h00;
    unique case (addr)
      OFF_ROM_ADDR0_HIGH: v = {3'h0, s.addr0[ROM_ADDR_W-1:16]};
      OFF_ROM_ADDR0_MID: v = s.addr0[15:8];
      OFF_ROM_ADDR0_LOW: v = s.addr0[7:0];
      OFF_ROM_ADDR1_HIGH: v = {3'h0, s.addr1[ROM_ADDR_W-1:16]};
      OFF_ROM_ADDR1_MID: v = s.addr1[15:8];
      OFF_ROM_ADDR1_LOW: v = s.addr1[7:0];
      OFF_VOICE_CONTROL:
      begin
        v[CTRL_DAC_EN_BIT] = s.dac_en;
        v[CTRL_ROM_EN_BIT] = s.rom_en;
        v[CTRL_SEL_BIT] = s.sel;
        v[CTRL_NORMAL_START_BIT] = s.normal_start; // [R14]
      end
      OFF_AUDIO_SAMPLE_LOW: v = {s.sample_lo, 4'h0}; // [R02]
      OFF_AUDIO_SAMPLE_HIGH: v = s.sample_hi;
      OFF_OUTPUT_VOLUME: v = {s.output_volume, 4'h0}; // [R04]
      OFF_ROM_READ_DATA: v = s.rom_en ? s.rom_data : 8'h00; // [R07] [R12]
      default: v = 8'h00;
    endcase
    return v;
  endfunction : reg_read

  // Restart on any write that can change the address presented to the ROM
  assign restart = I_WR_EN && (is_sel_addr(I_ADDR, st_reg.sel) || // [R13]
                   (I_ADDR == OFF_VOICE_CONTROL &&
                    (I_WDATA[CTRL_SEL_BIT] != st_reg.sel ||
                     (I_WDATA[CTRL_ROM_EN_BIT] && !st_reg.rom_en))));

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    st_next = st_reg;
    st_next.rdata_valid = I_RD_EN;
    if (I_RD_EN)
    begin
      st_next.rdata = reg_read(st_reg, I_ADDR);
    end
    if (I_WR_EN)
    begin
      unique case (I_ADDR)
        OFF_ROM_ADDR0_HIGH: st_next.addr0 = addr_write(st_reg.addr0, 2'h0, I_WDATA);
        OFF_ROM_ADDR0_MID: st_next.addr0 = addr_write(st_reg.addr0, 2'h1, I_WDATA);
        OFF_ROM_ADDR0_LOW: st_next.addr0 = addr_write(st_reg.addr0, 2'h2, I_WDATA);
        OFF_ROM_ADDR1_HIGH: st_next.addr1 = addr_write(st_reg.addr1, 2'h0, I_WDATA);
        OFF_ROM_ADDR1_MID: st_next.addr1 = addr_write(st_reg.addr1, 2'h1, I_WDATA);
        OFF_ROM_ADDR1_LOW: st_next.addr1 = addr_write(st_reg.addr1, 2'h2, I_WDATA);
        OFF_VOICE_CONTROL:
        begin
          // Halt has no path here, so only software moves the enable
          st_next.dac_en = I_WDATA[CTRL_DAC_EN_BIT]; // [R05] [R06]
          st_next.rom_en = I_WDATA[CTRL_ROM_EN_BIT]; // [R07]
          st_next.sel = I_WDATA[CTRL_SEL_BIT]; // [R08]
          st_next.normal_start = I_WDATA[CTRL_NORMAL_START_BIT]; // [R09]
        end
        OFF_AUDIO_SAMPLE_LOW: st_next.sample_lo = I_WDATA[7:4];
        OFF_AUDIO_SAMPLE_HIGH: st_next.sample_hi = I_WDATA;
        OFF_OUTPUT_VOLUME: st_next.output_volume = I_WDATA[7:4]; // [R03]
        default: st_next.output_volume = st_reg.output_volume;
      endcase
    end

    st_next.rom_addr = st_next.sel ? st_next.addr1 : st_next.addr0; // [R08] [R10]

    // Fetch timer: byte is taken only after the full access latency
    if (!st_next.rom_en)
    begin
      st_next.lat_cnt = '0;
      st_next.rom_ready = 1'b0; // [R07]
    end
    else if (restart)
    begin
      st_next.lat_cnt = LAT_LOAD; // [R11] [R13]
      st_next.rom_ready = 1'b0;
    end
    else if (st_reg.lat_cnt != '0)
    begin
      st_next.lat_cnt = st_reg.lat_cnt - 1'b1;
      if (st_reg.lat_cnt == LAT_W'(1))
      begin
        st_next.rom_data = I_ROM_DATA; // [R12]
        st_next.rom_ready = 1'b1;
      end
    end

    // Sample is muted rather than held, so a disabled DAC drives zero from the cycle after its enable clears
    st_next.dac_out = st_reg.dac_en ? {st_reg.sample_hi, st_reg.sample_lo} : '0; // [R01] [R05]
  end

  always_ff @(posedge I_CLK)
  begin
    if (!I_RESETN)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign O_RDATA = st_reg.rdata;
  assign O_RDATA_VALID = st_reg.rdata_valid;
  assign O_ROM_EN = st_reg.rom_en;
  assign O_ROM_ADDR = st_reg.rom_addr;
  assign O_ROM_READY = st_reg.rom_ready;
  assign O_DAC_EN = st_reg.dac_en;
  assign O_DAC_SAMPLE = st_reg.dac_out;
  assign O_VOLUME = st_reg.output_volume[3:1]; // [R03]
  assign O_XTAL_NORMAL_START = st_reg.normal_start;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESETN);

  // Cycles since the last fetch restart, saturating
  logic [LAT_W:0] since_restart;
  always_ff @(posedge I_CLK)
  begin
    if (!I_RESETN)
    begin
      since_restart <= '0;
    end
    else if (restart)
    begin
      since_restart <= '0;
    end
    else if (since_restart != '1)
    begin
      since_restart <= since_restart + 1'b1;
    end
  end

  // ----------------------------------------
  // Register read and output checks
  // ----------------------------------------
  // Read data lags its strobe by one cycle, so reads are judged at the next edge
  sequence s_read(logic [7:0] off);
    I_RD_EN && I_ADDR == off;
  endsequence

  sequence s_ctrl_write;
    I_WR_EN && I_ADDR == OFF_VOICE_CONTROL;
  endsequence

  a_sample_low_zero: assert property (s_read(OFF_AUDIO_SAMPLE_LOW) |=> O_RDATA[3:0] == 4'h0) // [R02]
    else $error("low sample nibble read not zero");

  a_volume_low_zero: assert property (s_read(OFF_OUTPUT_VOLUME) |=> O_RDATA[3:0] == 4'h0) // [R04]
    else $error("volume low nibble read not zero");

  a_ctrl_unused_zero: assert property (s_read(OFF_VOICE_CONTROL) |=> // [R14]
    (O_RDATA & 8'h69) == 8'h00)
    else $error("unused control bits read not zero");

  a_dac_off_silent: assert property (!O_DAC_EN |=> O_DAC_SAMPLE == '0) // [R05]
    else $error("sample present while dac disabled");

  a_sample_form: assert property (O_DAC_EN && $stable(O_DAC_EN) |-> // [R01]
    O_DAC_SAMPLE == $past({st_reg.sample_hi, st_reg.sample_lo}))
    else $error("dac sample not formed from high byte and low nibble");

  a_halt_keeps_dac: assert property (I_HALT && // [R06]
    !(I_WR_EN && I_ADDR == OFF_VOICE_CONTROL) |=> $stable(O_DAC_EN))
    else $error("dac enable moved without a control write");

  a_volume_level: assert property (I_WR_EN && I_ADDR == OFF_OUTPUT_VOLUME |=> // [R03]
    O_VOLUME == $past(I_WDATA[7:5]))
    else $error("volume level not taken from written nibble");

  a_rom_off_mute: assert property (!O_ROM_EN |-> !O_ROM_READY) // [R07]
    else $error("rom byte marked ready while rom disabled");

  a_rom_off_read: assert property (!O_ROM_EN ##0 s_read(OFF_ROM_READ_DATA) |=> // [R07]
    O_RDATA == 8'h00)
    else $error("rom data reachable while rom disabled");

  a_addr_select: assert property (O_ROM_ADDR == (st_reg.sel ? st_reg.addr1 : st_reg.addr0)) // [R08]
    else $error("rom address not from selected counter");

  a_xtal_start: assert property (s_ctrl_write |=> // [R09]
    O_XTAL_NORMAL_START == $past(I_WDATA[CTRL_NORMAL_START_BIT]))
    else $error("crystal start mode not written");

  a_fetch_latency: assert property ($rose(O_ROM_READY) |-> // [R11] [R13]
    since_restart == (LAT_W + 1)'(ROM_LAT_CYCLES))
    else $error("rom byte latched before access latency");

  a_restart_clears: assert property (restart && O_ROM_EN |=> !O_ROM_READY) // [R13]
    else $error("fetch not restarted by counter write");

  a_rom_latch: assert property ($rose(O_ROM_READY) |-> // [R10] [R12]
    st_reg.rom_data == $past(I_ROM_DATA) && $stable(O_ROM_ADDR))
    else $error("latched byte not from addressed rom word");

  // ----------------------------------------
  // Fetch hold and restart checks
  // ----------------------------------------
  sequence s_unsel_write;
    I_WR_EN && is_sel_addr(I_ADDR, !st_reg.sel);
  endsequence

  a_unsel_no_restart: assert property (O_ROM_READY ##0 s_unsel_write |=> O_ROM_READY) // [R13]
    else $error("write to unselected counter disturbed the fetch");

  // Only a restart or turning the ROM off may drop a fetched byte
  a_ready_holds: assert property (O_ROM_READY && !restart && // [R12]
    !(I_WR_EN && I_ADDR == OFF_VOICE_CONTROL && !I_WDATA[CTRL_ROM_EN_BIT]) |=>
    O_ROM_READY && $stable(st_reg.rom_data))
    else $error("fetched byte lost without restart");

  a_ready_not_early: assert property (restart |=> (!O_ROM_READY) [*8]) // [R11] [R13]
    else $error("rom byte ready too soon after restart");

  // ----------------------------------------
  // Control write and read strobe checks
  // ----------------------------------------
  a_dac_en_write: assert property (s_ctrl_write |=> // [R05] [R06]
    O_DAC_EN == $past(I_WDATA[CTRL_DAC_EN_BIT]))
    else $error("dac enable not taken from control write");

  a_rom_en_write: assert property (s_ctrl_write |=> // [R07]
    O_ROM_EN == $past(I_WDATA[CTRL_ROM_EN_BIT]))
    else $error("rom enable not taken from control write");

  a_sel_write: assert property (s_ctrl_write |=> // [R08]
    O_ROM_ADDR == ($past(I_WDATA[CTRL_SEL_BIT]) ? st_reg.addr1 : st_reg.addr0))
    else $error("counter select not taken from control write");

  a_read_valid: assert property (O_RDATA_VALID == $past(I_RD_EN))
    else $error("read valid not one cycle after strobe");

  a_addr_high_zero: assert property (I_RD_EN && // [R10]
    (I_ADDR == OFF_ROM_ADDR0_HIGH || I_ADDR == OFF_ROM_ADDR1_HIGH) |=> O_RDATA[7:5] == 3'h0)
    else $error("unused high address bits read not zero");

endmodule : voice_dac_ctrl

`default_nettype wire

// ===== dv/voice_rom_model.sv
// Behavioural voice ROM that answers the block's address with a byte
`timescale 1ns/1ps
`default_nettype none

module voice_rom_model
  import voice_dac_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_en,
  input wire logic [ROM_ADDR_W-1:0] i_addr,
  output logic [7:0] o_data
);
  logic [7:0] junk;

  // Disabled ROM shows a pattern that flips every cycle, never a stale byte
  always @(posedge i_clk)
  begin
    junk <= (junk === 8'h5A) ? 8'hA5 : 8'h5A;
  end

  assign o_data = i_en ? (i_addr[7:0] ^ i_addr[20:13]) : junk;
endmodule : voice_rom_model
`default_nettype wire

// ===== dv/voice_rom_and_dac_control_tb.sv
// Self-checking bench for the voice ROM and DAC register block
`timescale 1ns/1ps
`default_nettype none

module voice_rom_and_dac_control_tb;
  import voice_dac_pkg::*;
  logic clk = 1'b0;
  logic rstn, wr_en, rd_en, halt, rvalid, rom_en, rom_rdy, dac_en, xtal;
  logic [7:0] addr, wdata, rdata, rom_data, rv;
  logic [ROM_ADDR_W-1:0] rom_addr;
  logic [SAMPLE_W-1:0] sample;
  logic [VOL_LEVEL_W-1:0] output_volume;
  int n_mismatch = 0;
  int samples_checked = 0;

  voice_dac_ctrl dut_u (.I_CLK(clk), .I_RESETN(rstn), .I_ADDR(addr), .I_WR_EN(wr_en),
    .I_WDATA(wdata), .I_RD_EN(rd_en), .O_RDATA(rdata), .O_RDATA_VALID(rvalid),
    .I_HALT(halt), .O_ROM_EN(rom_en), .O_ROM_ADDR(rom_addr), .I_ROM_DATA(rom_data),
    .O_ROM_READY(rom_rdy), .O_DAC_EN(dac_en), .O_DAC_SAMPLE(sample), .O_VOLUME(output_volume),
    .O_XTAL_NORMAL_START(xtal));
  voice_rom_model rom_u (.i_clk(clk), .i_en(rom_en), .i_addr(rom_addr), .o_data(rom_data));

  // ----------------------------------------
  // Bus helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  // Idle cycle at the end keeps strobes from being raised twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
    @(negedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    addr = a;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    chk("read valid", 1, rvalid);
    rv = rdata;
    @(negedge clk);
  endtask : rd

  task automatic close_out;
    $display("checked %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_control;
    rd(OFF_VOICE_CONTROL);
    chk("control reset", VOICE_CONTROL_RESET, rv);
    chk("xtal start", 0, xtal);
    rd(8'h00);
    chk("unmapped", 8'h00, rv);
    wr(OFF_VOICE_CONTROL, 8'hFF);
    rd(OFF_VOICE_CONTROL);
    chk("control bits", 8'h96, rv);
    chk("xtal start", 1, xtal);
    wr(OFF_VOICE_CONTROL, 8'h00);
  endtask : t_control

  task automatic t_dac;
    halt = 1'b1;
    wr(OFF_VOICE_CONTROL, 8'h02);
    wr(OFF_AUDIO_SAMPLE_LOW, 8'hAB);
    wr(OFF_AUDIO_SAMPLE_HIGH, 8'hCD);
    rd(OFF_AUDIO_SAMPLE_LOW);
    chk("sample low", 8'hA0, rv);
    rd(OFF_AUDIO_SAMPLE_HIGH);
    chk("sample high", 8'hCD, rv);
    chk("dac sample", 12'hCDA, sample);
    chk("dac on in halt", 1, dac_en);
    wr(OFF_VOICE_CONTROL, 8'h00);
    chk("dac off", 0, dac_en);
    @(negedge clk);
    chk("sample off", 0, sample);
    halt = 1'b0;
  endtask : t_dac

  task automatic t_volume;
    wr(OFF_OUTPUT_VOLUME, 8'hFF);
    rd(OFF_OUTPUT_VOLUME);
    chk("volume nibble", 8'hF0, rv);
    for (int l = 0; l < 8; l++)
    begin
      wr(OFF_OUTPUT_VOLUME, 8'(l << 5));
      chk("volume level", l, output_volume);
    end
  endtask : t_volume

  // Entered one cycle after the restart edge; ready is due at cycle 160
  task automatic wait_ready(input logic [ROM_ADDR_W-1:0] a);
    int early;
    early = 0;
    chk("ready cleared", 0, rom_rdy);
    repeat (158)
    begin
      @(negedge clk);
      if (rom_rdy !== 1'b0)
        early++;
    end
    chk("early ready", 0, early);
    @(negedge clk);
    chk("ready", 1, rom_rdy);
    chk("rom addr", a, rom_addr);
    rd(OFF_ROM_READ_DATA);
    chk("rom data", a[7:0] ^ a[20:13], rv);
  endtask : wait_ready

  task automatic t_rom;
    wr(OFF_VOICE_CONTROL, 8'h04);
    wr(OFF_ROM_ADDR0_LOW, 8'h34);
    wr(OFF_ROM_ADDR0_MID, 8'h12);
    wr(OFF_ROM_ADDR0_HIGH, 8'hFF);
    wait_ready(21'h1F1234);
    rd(OFF_ROM_ADDR0_HIGH);
    chk("addr high bits", 8'h1F, rv);
    wr(OFF_ROM_ADDR1_LOW, 8'h77);
    chk("unselected write", 1, rom_rdy);
    wr(OFF_ROM_ADDR1_MID, 8'h00);
    wr(OFF_ROM_ADDR1_HIGH, 8'h03);
    wr(OFF_VOICE_CONTROL, 8'h14);
    wait_ready(21'h030077);
    wr(OFF_ROM_ADDR1_MID, 8'h5C);
    wait_ready(21'h035C77);
    wr(OFF_VOICE_CONTROL, 8'h10);
    chk("rom off", 0, rom_en);
    chk("ready off", 0, rom_rdy);
    rd(OFF_ROM_READ_DATA);
    chk("rom data off", 0, rv);
  endtask : t_rom

  // Mid-run reset must bring the control register back to its default
  task automatic t_reset;
    wr(OFF_VOICE_CONTROL, 8'hFF);
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    chk("dac after reset", 0, dac_en);
    chk("rom after reset", 0, rom_en);
    chk("xtal after reset", 0, xtal);
    rd(OFF_VOICE_CONTROL);
    chk("control after reset", VOICE_CONTROL_RESET, rv);
  endtask : t_reset

  // ----------------------------------------
  // Clock, sequence and watchdog
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial
  begin
    {rstn, wr_en, rd_en, halt} = 4'h0;
    addr = 8'h00;
    wdata = 8'h00;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    t_control();
    t_dac();
    t_volume();
    t_rom();
    t_reset();
    close_out();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    close_out();
  end
endmodule : voice_rom_and_dac_control_tb
`default_nettype wire
